// ===== pwmst_defs.svh
// Offsets, field positions, reset values and counts for the PWM output steering block.
// Assumes a 250 MHz system clock and an AXI4-Lite register port with 32-bit data.
// Summary of operation
// - With sync set, steering changes wait for the next PWM period start.
// - With sync clear, steering changes apply at the next instruction-cycle boundary.
// - In single-output PWM mode, enabled outputs drive the PWM waveform, polarity from the low mode bits.
// - Disabled outputs are released to their general-purpose port function.
`ifndef PWMST_DEFS_SVH
`define PWMST_DEFS_SVH
`define PWMST_STEER_OFS 8'h00
`define PWMST_CCP_OFS 8'h04
`define PWMST_STAT_OFS 8'h08
`define PWMST_STEER_RST 5'h01
`define PWMST_CCP_RST 8'h00
`define PWMST_SYNC_BIT 4
`define PWMST_MODE_PWM 2'h3
`define PWMST_CFG_SINGLE 2'h0
`define PWMST_APPLIED_RST 4'h1
`define PWMST_INSTR_DIV 4
`define PWMST_RESP_OKAY 2'h0
`define PWMST_RESP_DECERR 2'h3
`endif

// ===== pwmst_pkg.sv
// Types shared by the PWM output steering block.
// Assumes pwmst_defs.svh is compiled alongside.
package pwmst_pkg;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pwmst_pins_s;
  typedef struct packed {
    logic [4:0] steer;
    logic [7:0] ccp;
    logic [3:0] applied;
    logic [1:0] div;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    pwmst_pins_s pins;
  } pwmst_state_s;
endpackage : pwmst_pkg

// ===== pwmst_top.sv
// PWM output steering with an AXI4-Lite register port.
// Assumes one 250 MHz clock, synchronous inputs and an outside PWM period-start pulse.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "pwmst_defs.svh"
module pwmst_top #(
  parameter int DIV_W = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_pwm_wave,
  input wire logic i_period_start,
  input wire logic [3:0] i_port_out,
  input wire logic [3:0] i_port_oe,
  output logic [3:0] o_pwm_out,
  output logic [3:0] o_pwm_oe
);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(`PWMST_INSTR_DIV - 1);

  pwmst_pkg::pwmst_state_s s_r;
  pwmst_pkg::pwmst_state_s s_nxt;
  logic instr_en;
  logic active;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_strb;
  logic [3:0] wave;
  logic wr_done;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes and derived terms.
  assign o_awready = !s_r.aw_got && !s_r.bvalid;
  assign o_wready = !s_r.w_got && !s_r.bvalid;
  assign o_arready = !s_r.rvalid;
  assign aw_hs = i_awvalid && o_awready;
  assign w_hs = i_wvalid && o_wready;
  assign ar_hs = i_arvalid && o_arready;
  assign o_bvalid = s_r.bvalid;
  assign o_bresp = s_r.bresp;
  assign o_rvalid = s_r.rvalid;
  assign o_rresp = s_r.rresp;
  assign o_rdata = {24'h000000, s_r.rdata};
  assign o_pwm_out = s_r.pins.out;
  assign o_pwm_oe = s_r.pins.oe;
  assign instr_en = (s_r.div == DIV_LAST);
  assign wr_addr = aw_hs ? i_awaddr : s_r.awaddr;
  assign wr_data = w_hs ? i_wdata[7:0] : s_r.wdata;
  assign wr_strb = w_hs ? i_wstrb[0] : s_r.wstrb0;
  assign wr_done = (aw_hs || s_r.aw_got) && (w_hs || s_r.w_got) && !s_r.bvalid;
  assign active = (s_r.ccp[3:2] == `PWMST_MODE_PWM) && (s_r.ccp[7:6] == `PWMST_CFG_SINGLE);
  assign wave = {i_pwm_wave ^ s_r.ccp[0], i_pwm_wave ^ s_r.ccp[1],
                 i_pwm_wave ^ s_r.ccp[0], i_pwm_wave ^ s_r.ccp[1]};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    s_nxt = s_r;
    s_nxt.div = instr_en ? '0 : s_r.div + 2'h1;
    if (s_r.steer[`PWMST_SYNC_BIT]) begin
      if (i_period_start) begin
        s_nxt.applied = s_r.steer[3:0];
      end
    end else if (instr_en) begin
      s_nxt.applied = s_r.steer[3:0];
    end
    for (int i = 0; i < 4; i++) begin
      if (active && s_r.applied[i]) begin
        s_nxt.pins.out[i] = wave[i];
        s_nxt.pins.oe[i] = 1'b1;
      end else begin
        s_nxt.pins.out[i] = i_port_out[i];
        s_nxt.pins.oe[i] = i_port_oe[i];
      end
    end
    if (aw_hs) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = i_awaddr;
    end
    if (w_hs) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = i_wdata[7:0];
      s_nxt.wstrb0 = i_wstrb[0];
    end
    if (wr_done) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `PWMST_RESP_OKAY;
      case (wr_addr)
        `PWMST_STEER_OFS: begin
          if (wr_strb) begin
            s_nxt.steer = wr_data[4:0];
          end
        end
        `PWMST_CCP_OFS: begin
          if (wr_strb) begin
            s_nxt.ccp = wr_data;
          end
        end
        `PWMST_STAT_OFS: begin
          s_nxt.bresp = `PWMST_RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = `PWMST_RESP_DECERR;
        end
      endcase
    end else if (s_r.bvalid && i_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (ar_hs) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `PWMST_RESP_OKAY;
      case (i_araddr)
        `PWMST_STEER_OFS: begin
          s_nxt.rdata = {3'h0, s_r.steer};
        end
        `PWMST_CCP_OFS: begin
          s_nxt.rdata = s_r.ccp;
        end
        `PWMST_STAT_OFS: begin
          s_nxt.rdata = {3'h0, active, s_r.applied};
        end
        default: begin
          s_nxt.rdata = 8'h00;
          s_nxt.rresp = `PWMST_RESP_DECERR;
        end
      endcase
    end else if (s_r.rvalid && i_rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r <= '0;
      s_r.steer <= `PWMST_STEER_RST;
      s_r.ccp <= `PWMST_CCP_RST;
      s_r.applied <= `PWMST_APPLIED_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_sync_hold;
    s_r.steer[`PWMST_SYNC_BIT] && !i_period_start;
  endsequence

  sequence s_drive_a;
    active && s_r.applied[0];
  endsequence

  property p_period_hold;
    s_sync_hold |=> $stable(s_r.applied);
  endproperty
  a_period_hold: assert property (p_period_hold) else $error("Steering changed mid period.");

  property p_period_load;
    s_r.steer[`PWMST_SYNC_BIT] && i_period_start |=> s_r.applied == $past(s_r.steer[3:0]);
  endproperty
  a_period_load: assert property (p_period_load) else $error("Steering not loaded at period.");

  property p_instr_load;
    !s_r.steer[`PWMST_SYNC_BIT] && instr_en |=> s_r.applied == $past(s_r.steer[3:0]);
  endproperty
  a_instr_load: assert property (p_instr_load) else $error("Steering not applied at boundary.");

  property p_drive_a;
    s_drive_a |=> o_pwm_oe[0] && o_pwm_out[0] == ($past(i_pwm_wave) ^ $past(s_r.ccp[1]));
  endproperty
  a_drive_a: assert property (p_drive_a) else $error("Output A not driving waveform.");

  property p_drive_b;
    active && s_r.applied[1] |=>
      o_pwm_oe[1] && o_pwm_out[1] == ($past(i_pwm_wave) ^ $past(s_r.ccp[0]));
  endproperty
  a_drive_b: assert property (p_drive_b) else $error("Output B not driving waveform.");

  property p_release;
    !s_r.applied[2] |=> o_pwm_out[2] == $past(i_port_out[2]) && o_pwm_oe[2] == $past(i_port_oe[2]);
  endproperty
  a_release: assert property (p_release) else $error("Output C not released to port.");

  property p_inactive;
    !active |=> o_pwm_out == $past(i_port_out) && o_pwm_oe == $past(i_port_oe);
  endproperty
  a_inactive: assert property (p_inactive) else $error("Steering acted outside PWM mode.");

  property p_read_answer;
    ar_hs |=> o_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("Read not answered in one cycle.");

  sequence s_instr_gap;
    (!instr_en) [*3] ##1 instr_en;
  endsequence

  property p_instr_pulse;
    instr_en |=> s_instr_gap;
  endproperty
  a_instr_pulse: assert property (p_instr_pulse) else $error("Boundary spacing wrong.");

  property p_applied_hold;
    !(s_r.steer[`PWMST_SYNC_BIT] ? i_period_start : instr_en) |=> $stable(s_r.applied);
  endproperty
  a_applied_hold: assert property (p_applied_hold) else $error("Steering moved early.");

  property p_drive_c;
    active && s_r.applied[2] |=>
      o_pwm_oe[2] && o_pwm_out[2] == ($past(i_pwm_wave) ^ $past(s_r.ccp[1]));
  endproperty
  a_drive_c: assert property (p_drive_c) else $error("Output C not driving waveform.");

  property p_drive_d;
    active && s_r.applied[3] |=>
      o_pwm_oe[3] && o_pwm_out[3] == ($past(i_pwm_wave) ^ $past(s_r.ccp[0]));
  endproperty
  a_drive_d: assert property (p_drive_d) else $error("Output D not driving waveform.");

  property p_release_a;
    !s_r.applied[0] |=> o_pwm_out[0] == $past(i_port_out[0]) && o_pwm_oe[0] == $past(i_port_oe[0]);
  endproperty
  a_release_a: assert property (p_release_a) else $error("Output A not released to port.");

  property p_release_b;
    !s_r.applied[1] |=> o_pwm_out[1] == $past(i_port_out[1]) && o_pwm_oe[1] == $past(i_port_oe[1]);
  endproperty
  a_release_b: assert property (p_release_b) else $error("Output B not released to port.");

  property p_release_d;
    !s_r.applied[3] |=> o_pwm_out[3] == $past(i_port_out[3]) && o_pwm_oe[3] == $past(i_port_oe[3]);
  endproperty
  a_release_d: assert property (p_release_d) else $error("Output D not released to port.");

  property p_write_resp;
    wr_done |=> o_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("Write not answered.");

  property p_steer_write;
    wr_done && wr_addr == `PWMST_STEER_OFS && wr_strb |=> s_r.steer == $past(wr_data[4:0]);
  endproperty
  a_steer_write: assert property (p_steer_write) else $error("Steering write lost.");

  property p_strb_keep;
    wr_done && !wr_strb |=> $stable(s_r.steer) && $stable(s_r.ccp);
  endproperty
  a_strb_keep: assert property (p_strb_keep) else $error("Masked write changed a register.");

  property p_read_decerr;
    ar_hs && !(i_araddr inside {`PWMST_STEER_OFS, `PWMST_CCP_OFS, `PWMST_STAT_OFS}) |=>
      o_rresp == `PWMST_RESP_DECERR && o_rdata == 32'h00000000;
  endproperty
  a_read_decerr: assert property (p_read_decerr) else $error("Unmapped read not refused.");

  property p_write_decerr;
    wr_done && !(wr_addr inside {`PWMST_STEER_OFS, `PWMST_CCP_OFS, `PWMST_STAT_OFS}) |=>
      o_bresp == `PWMST_RESP_DECERR;
  endproperty
  a_write_decerr: assert property (p_write_decerr) else $error("Unmapped write not refused.");

  property p_aw_refuse;
    o_bvalid |-> !o_awready && !o_wready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse) else $error("Write taken while response waits.");

  property p_ar_refuse;
    o_rvalid |-> !o_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("Read taken while data waits.");

  property p_bresp_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("Write response not held.");

  property p_rdata_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("Read data not held.");

  property p_b_drop;
    o_bvalid && i_bready |=> !o_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("Write response repeated.");

  property p_r_drop;
    o_rvalid && i_rready |=> !o_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("Read data repeated.");

  property p_rdata_upper;
    o_rvalid |-> o_rdata[31:8] == 24'h000000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("Upper read bits not zero.");

endmodule : pwmst_top

// ===== tb.sv
// Self-checking bench for the PWM output steering block.
// Assumes pwmst_defs.svh, pwmst_pkg.sv and pwmst_top.sv are compiled first.
`timescale 1ns/1ps
`include "pwmst_defs.svh"
module tb;
  logic i_ref_clk = 1'h0, i_resetn = 1'h0, i_awvalid = 1'h0, i_wvalid = 1'h0;
  logic i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0, pin_on = 1'h0;
  logic i_pwm_wave = 1'h0, i_period_start = 1'h0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, ex_ccp = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hF, i_port_out = 4'h0, i_port_oe = 4'h0, ex_steer = 4'h1;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [3:0] o_pwm_out, o_pwm_oe;
  int errors = 0, cmp_count = 0, cyc = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] pq[$];
  pwmst_top i_dut (.i_ref_clk, .i_resetn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pwm_wave, .i_period_start,
    .i_port_out, .i_port_oe, .o_pwm_out, .o_pwm_oe);
  always #2 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
    cmp_count++;
    if (e !== s) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Expected pins: enabled outputs carry the wave, the rest follow the port.
  function automatic logic [7:0] pins_f(input logic w, input logic [3:0] po, input logic [3:0] pe);
    logic [3:0] en, wv;
    en = (ex_ccp[3:2] == 2'h3 && ex_ccp[7:6] == 2'h0) ? ex_steer : 4'h0;
    wv = {w ^ ex_ccp[0], w ^ ex_ccp[1], w ^ ex_ccp[0], w ^ ex_ccp[1]};
    return {(en & wv) | (~en & po), en | (~en & pe)};
  endfunction : pins_f
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    @(posedge i_ref_clk);
    bq.push_back(r);
    i_awaddr <= a;
    i_wdata <= {24'($urandom), d};
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    fork
      begin do @(posedge i_ref_clk); while (!o_awready); i_awvalid <= 1'h0; end
      begin do @(posedge i_ref_clk); while (!o_wready); i_wvalid <= 1'h0; end
    join
    do @(posedge i_ref_clk); while (!o_bvalid);
    i_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge i_ref_clk);
    rq.push_back(e);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do @(posedge i_ref_clk); while (!o_arready);
    i_arvalid <= 1'h0;
    do @(posedge i_ref_clk); while (!o_rvalid);
    i_rready <= 1'h0;
  endtask : rd
  task automatic run(input logic [7:0] c, input logic [3:0] s);
    ex_ccp = c;
    ex_steer = s;
    repeat (6) @(posedge i_ref_clk);
    pin_on <= 1'h1;
    repeat (24) @(posedge i_ref_clk);
    pin_on <= 1'h0;
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_ref_clk) begin
    if (pin_on) pq.push_back(pins_f(i_pwm_wave, i_port_out, i_port_oe));
    i_pwm_wave <= 1'($urandom);
    i_port_out <= 4'($urandom);
    i_port_oe <= 4'($urandom);
  end
  always @(negedge i_ref_clk) begin
    if (pq.size() > 0) chk("pins", pq.pop_front(), {o_pwm_out, o_pwm_oe});
    if (o_rvalid && i_rready) chk("rdata", rq.pop_front(), {o_rresp, o_rdata});
    if (o_bvalid && i_bready) chk("bresp", bq.pop_front(), o_bresp);
  end
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      complete_run;
    end
  end
  initial begin
    void'($urandom(44));
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'h1;
    rd(`PWMST_STEER_OFS, 34'h1);
    rd(`PWMST_CCP_OFS, 34'h0);
    rd(8'h0C, {`PWMST_RESP_DECERR, 32'h0});
    run(8'h00, 4'h1);
    wr(8'h0C, 8'hFF, `PWMST_RESP_DECERR);
    $display("test reset and decode done");
    wr(`PWMST_STEER_OFS, 8'h0F);
    for (int p = 0; p < 4; p++) begin
      wr(`PWMST_CCP_OFS, 8'h0C | 8'(p));
      run(8'h0C | 8'(p), 4'hF);
    end
    wr(`PWMST_STEER_OFS, 8'h05);
    run(8'h0F, 4'h5);
    rd(`PWMST_STAT_OFS, 34'h15);
    $display("test polarity and release done");
    wr(`PWMST_STEER_OFS, 8'h12);
    run(8'h0F, 4'h5);
    rd(`PWMST_STAT_OFS, 34'h15);
    i_period_start <= 1'h1;
    @(posedge i_ref_clk);
    i_period_start <= 1'h0;
    rd(`PWMST_STAT_OFS, 34'h12);
    run(8'h0F, 4'h2);
    $display("test period sync done");
    i_wstrb <= 4'hE;
    wr(`PWMST_STEER_OFS, 8'h05);
    i_wstrb <= 4'hF;
    rd(`PWMST_STEER_OFS, 34'h12);
    $display("test masked write done");
    wr(`PWMST_CCP_OFS, 8'h4F);
    run(8'h4F, 4'h2);
    rd(`PWMST_STAT_OFS, 34'h02);
    wr(`PWMST_CCP_OFS, 8'h0B);
    run(8'h0B, 4'h2);
    $display("test mode gating done");
    @(posedge i_ref_clk);
    i_resetn <= 1'h0;
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'h1;
    rd(`PWMST_STEER_OFS, 34'h1);
    rd(`PWMST_STAT_OFS, 34'h01);
    $display("test mid-run reset done");
    complete_run;
  end
endmodule : tb
